// ---- rtl/flash_status_error_irq_ctrl.sv ----
// Status, configuration and interrupt logic of the flash controller.
// Assumes a single-cycle register port and sequencer events synchronous to i_core_clk.
module flash_status_error_irq_ctrl
  import flash_status_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire seq_evt_s    i_seq_evt,
  output logic      [7:0]  o_rd_data,
  output logic             o_cmd_launch,
  output logic             o_cmd_irq,
  output logic             o_fault_irq,
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  logic [7:0] config_ff;
  logic [7:0] err_cfg_ff;
  logic       cmd_done_ff;
  logic       acc_err_ff;
  logic       sf_flag_ff;
  logic       df_flag_ff;
  logic [7:0] rd_data_ff;

  logic [7:0] nxt_config;
  logic [7:0] nxt_err_cfg;
  logic       nxt_cmd_done;
  logic       nxt_acc_err;
  logic       nxt_sf_flag;
  logic       nxt_df_flag;
  logic [7:0] nxt_rd_data;

  // ----------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------
  wire sel_cfg  = (i_addr == ADDR_CONFIG);
  wire sel_ecfg = (i_addr == ADDR_ERR_CFG);
  wire sel_stat = (i_addr == ADDR_STATUS);
  wire sel_est  = (i_addr == ADDR_ERR_STAT);

  wire wr_cfg   = i_wr_en & sel_cfg;
  wire wr_ecfg  = i_wr_en & sel_ecfg;
  wire wr_stat  = i_wr_en & sel_stat;
  wire wr_est   = i_wr_en & sel_est;

  // ----------------------------------------------------------------
  // Field views.
  // ----------------------------------------------------------------
  wire cmd_done_irq_en     = config_ff[BIT_CMD_DONE_IRQ_EN];
  wire ignore_single_fault = config_ff[BIT_IGNORE_SF];
  wire force_double_fault  = config_ff[BIT_FORCE_DF];
  wire force_single_fault  = config_ff[BIT_FORCE_SF];
  wire double_fault_irq_en = err_cfg_ff[BIT_DF_IRQ_EN];
  wire single_fault_irq_en = err_cfg_ff[BIT_SF_IRQ_EN];

  // ----------------------------------------------------------------
  // Configuration registers.
  // ----------------------------------------------------------------
  // Force bits are plain storage, so only reset or a software write of zero clears them.
  assign nxt_config  = wr_cfg ? (i_wr_data & MASK_CONFIG) : config_ff;
  assign nxt_err_cfg = wr_ecfg ? (i_wr_data & MASK_ERR_CFG) : err_cfg_ff;

  // ----------------------------------------------------------------
  // Command launch and status flags.
  // ----------------------------------------------------------------
  wire launch_req   = wr_stat & i_wr_data[BIT_CMD_DONE];
  wire acc_clr      = wr_stat & i_wr_data[BIT_ACC_ERR];
  wire acc_set      = i_seq_evt.seq_error | i_seq_evt.cmd_violation;
  wire cmd_done_set = i_seq_evt.cmd_done | i_seq_evt.cmd_violation;
  // A launch needs an idle sequencer and no pending or arriving access error.
  wire launch_ok    = launch_req & cmd_done_ff & ~acc_err_ff & ~acc_set;

  assign o_cmd_launch = launch_ok;

  // Hardware set wins over software clear in the same cycle.
  assign nxt_cmd_done = cmd_done_set | (cmd_done_ff & ~launch_ok);
  assign nxt_acc_err  = acc_set | (acc_err_ff & ~acc_clr);

  // ----------------------------------------------------------------
  // Fault flags.
  // ----------------------------------------------------------------
  wire sf_real = i_seq_evt.single_fault & ~ignore_single_fault;
  wire sf_set  = i_seq_evt.array_read & (force_single_fault | sf_real);
  wire df_set  = i_seq_evt.array_read & (force_double_fault | i_seq_evt.double_fault);
  wire sf_clr  = wr_est & i_wr_data[BIT_SF_FLAG];
  wire df_clr  = wr_est & i_wr_data[BIT_DF_FLAG];

  assign nxt_sf_flag = sf_set | (sf_flag_ff & ~sf_clr);
  assign nxt_df_flag = df_set | (df_flag_ff & ~df_clr);

  // ----------------------------------------------------------------
  // Interrupts.
  // ----------------------------------------------------------------
  assign o_cmd_irq   = cmd_done_ff & cmd_done_irq_en;
  assign o_fault_irq = (df_flag_ff & double_fault_irq_en)
                     | (sf_flag_ff & single_fault_irq_en);
  assign o_irq       = o_cmd_irq | o_fault_irq;

  // ----------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------
  wire [7:0] stat_view = {cmd_done_ff, 1'b0, acc_err_ff, 5'h00};
  wire [7:0] est_view  = {6'h00, df_flag_ff, sf_flag_ff};
  wire [7:0] rd_mux    = sel_cfg  ? config_ff  :
                         sel_ecfg ? err_cfg_ff :
                         sel_stat ? stat_view  :
                         sel_est  ? est_view   : 8'h00;

  assign nxt_rd_data = i_rd_en ? rd_mux : 8'h00;
  assign o_rd_data   = rd_data_ff;

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      config_ff   <= RST_CONFIG;
      err_cfg_ff  <= RST_ERR_CFG;
      cmd_done_ff <= RST_STATUS[BIT_CMD_DONE];
      acc_err_ff  <= RST_STATUS[BIT_ACC_ERR];
      sf_flag_ff  <= RST_ERR_STAT[BIT_SF_FLAG];
      df_flag_ff  <= RST_ERR_STAT[BIT_DF_FLAG];
      rd_data_ff  <= 8'h00;
    end else begin
      config_ff   <= nxt_config;
      err_cfg_ff  <= nxt_err_cfg;
      cmd_done_ff <= nxt_cmd_done;
      acc_err_ff  <= nxt_acc_err;
      sf_flag_ff  <= nxt_sf_flag;
      df_flag_ff  <= nxt_df_flag;
      rd_data_ff  <= nxt_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking

  property p_cmd_irq;
    disable iff (i_sys_rst)
    (i_seq_evt.cmd_done && cmd_done_irq_en && !wr_cfg) |=> o_cmd_irq && o_irq;
  endproperty
  a_cmd_irq: assert property (p_cmd_irq) else $error("done interrupt missing");

  property p_sf_report;
    disable iff (i_sys_rst)
    (i_seq_evt.array_read && i_seq_evt.single_fault && !ignore_single_fault) |=> sf_flag_ff;
  endproperty
  a_sf_report: assert property (p_sf_report) else $error("single fault not recorded");

  property p_sf_ignore;
    disable iff (i_sys_rst)
    (ignore_single_fault && !force_single_fault && !sf_flag_ff && !wr_cfg)
      ##0 (i_seq_evt.array_read && i_seq_evt.single_fault)
      |=> !sf_flag_ff && (o_fault_irq == (df_flag_ff && double_fault_irq_en));
  endproperty
  a_sf_ignore: assert property (p_sf_ignore) else $error("ignored fault recorded");

  property p_force_df;
    disable iff (i_sys_rst)
    (i_seq_evt.array_read && force_double_fault) |=> df_flag_ff ##0
      (!double_fault_irq_en || o_fault_irq);
  endproperty
  a_force_df: assert property (p_force_df) else $error("forced double fault lost");

  property p_keep_df;
    disable iff (i_sys_rst)
    (force_double_fault && !wr_cfg) |=> force_double_fault;
  endproperty
  a_keep_df: assert property (p_keep_df) else $error("force double cleared by itself");

  property p_force_sf;
    disable iff (i_sys_rst)
    (i_seq_evt.array_read && force_single_fault) |=> sf_flag_ff;
  endproperty
  a_force_sf: assert property (p_force_sf) else $error("forced single fault lost");

  property p_keep_sf;
    disable iff (i_sys_rst)
    (force_single_fault && !(wr_cfg && !i_wr_data[BIT_FORCE_SF])) |=> force_single_fault;
  endproperty
  a_keep_sf: assert property (p_keep_sf) else $error("force single cleared by itself");

  property p_df_irq;
    disable iff (i_sys_rst)
    (df_flag_ff && double_fault_irq_en) |-> o_fault_irq && o_irq;
  endproperty
  a_df_irq: assert property (p_df_irq) else $error("double fault interrupt missing");

  property p_sf_irq;
    disable iff (i_sys_rst)
    (sf_flag_ff && single_fault_irq_en) |-> o_fault_irq;
  endproperty
  a_sf_irq: assert property (p_sf_irq) else $error("single fault interrupt missing");

  property p_launch;
    disable iff (i_sys_rst)
    (o_cmd_launch && !cmd_done_set) |=> !cmd_done_ff && !o_cmd_irq;
  endproperty
  a_launch: assert property (p_launch) else $error("launch did not clear done flag");

  property p_done_hold;
    disable iff (i_sys_rst)
    (!cmd_done_ff && !cmd_done_set) |=> !cmd_done_ff;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done flag rose alone");

  property p_acc_set;
    disable iff (i_sys_rst)
    acc_set |=> acc_err_ff ##1 (acc_err_ff || $past(acc_clr));
  endproperty
  a_acc_set: assert property (p_acc_set) else $error("access error not set");

  property p_acc_block;
    disable iff (i_sys_rst)
    (acc_err_ff && launch_req) |-> !o_cmd_launch
      ##1 (cmd_done_ff == $past(cmd_done_ff) || $past(cmd_done_set));
  endproperty
  a_acc_block: assert property (p_acc_block) else $error("launch despite access error");

  property p_acc_w0;
    disable iff (i_sys_rst)
    (acc_err_ff && !acc_clr) |=> acc_err_ff;
  endproperty
  a_acc_w0: assert property (p_acc_w0) else $error("access error lost without w1c");

  property p_acc_w1;
    disable iff (i_sys_rst)
    (acc_err_ff && acc_clr && !acc_set) |=> !acc_err_ff;
  endproperty
  a_acc_w1: assert property (p_acc_w1) else $error("access error not cleared");

  property p_reset_vals;
    i_sys_rst |=> (stat_view == RST_STATUS) && (config_ff == RST_CONFIG)
      && (err_cfg_ff == RST_ERR_CFG);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset");

  property p_irq_drop;
    disable iff (i_sys_rst)
    (!double_fault_irq_en && !single_fault_irq_en) |-> !o_fault_irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("fault irq without enable");

  property p_rsv_read;
    disable iff (i_sys_rst)
    (i_rd_en && sel_cfg) |=> ((o_rd_data & ~MASK_CONFIG) == 8'h00)
      && (o_rd_data == $past(config_ff));
  endproperty
  a_rsv_read: assert property (p_rsv_read) else $error("config readback wrong");

  property p_stat_read;
    disable iff (i_sys_rst)
    (i_rd_en && sel_stat) |=> ((o_rd_data & ~MASK_STATUS) == 8'h00)
      && (o_rd_data[BIT_CMD_DONE] == $past(cmd_done_ff))
      ##1 (o_rd_data == 8'h00 || $past(i_rd_en));
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status readback wrong");

  property p_cmd_irq_off;
    disable iff (i_sys_rst)
    !cmd_done_irq_en |-> !o_cmd_irq;
  endproperty
  a_cmd_irq_off: assert property (p_cmd_irq_off) else $error("done irq not masked");

  property p_df_report;
    disable iff (i_sys_rst)
    (i_seq_evt.array_read && i_seq_evt.double_fault) |=> df_flag_ff;
  endproperty
  a_df_report: assert property (p_df_report) else $error("double fault not recorded");

  property p_df_only;
    disable iff (i_sys_rst)
    (!df_flag_ff && !(i_seq_evt.array_read && (force_double_fault || i_seq_evt.double_fault)))
      |=> !df_flag_ff;
  endproperty
  a_df_only: assert property (p_df_only) else $error("double flag without cause");

  property p_sf_only;
    disable iff (i_sys_rst)
    (!sf_flag_ff && !(i_seq_evt.array_read && (force_single_fault || i_seq_evt.single_fault)))
      |=> !sf_flag_ff;
  endproperty
  a_sf_only: assert property (p_sf_only) else $error("single flag without cause");

  property p_launch_busy;
    disable iff (i_sys_rst)
    (launch_req && !cmd_done_ff) |-> !o_cmd_launch;
  endproperty
  a_launch_busy: assert property (p_launch_busy) else $error("launch while running");

  property p_launch_go;
    disable iff (i_sys_rst)
    (launch_req && cmd_done_ff && !acc_err_ff && !acc_set) |-> o_cmd_launch;
  endproperty
  a_launch_go: assert property (p_launch_go) else $error("launch write refused");

  property p_done_set;
    disable iff (i_sys_rst)
    cmd_done_set |=> cmd_done_ff;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_ecfg_read;
    disable iff (i_sys_rst)
    (i_rd_en && sel_ecfg) |=> ((o_rd_data & ~MASK_ERR_CFG) == 8'h00)
      && (o_rd_data == $past(err_cfg_ff));
  endproperty
  a_ecfg_read: assert property (p_ecfg_read) else $error("err config readback");

  property p_df_irq_drop;
    disable iff (i_sys_rst)
    (wr_est && i_wr_data[BIT_DF_FLAG] && !df_set && !sf_set && !sf_flag_ff) |=> !o_fault_irq;
  endproperty
  a_df_irq_drop: assert property (p_df_irq_drop) else $error("fault irq after clear");

  c_launch: cover property (disable iff (i_sys_rst) o_cmd_launch ##[1:50] i_seq_evt.cmd_done);
  c_blocked: cover property (disable iff (i_sys_rst) acc_err_ff && launch_req);
  c_force_df: cover property (disable iff (i_sys_rst)
    df_set && force_double_fault ##1 o_fault_irq);
  c_ignored: cover property (disable iff (i_sys_rst)
    ignore_single_fault && i_seq_evt.single_fault);
  c_acc_clear: cover property (disable iff (i_sys_rst) acc_err_ff && acc_clr);

endmodule

// ---- rtl/flash_status_pkg.sv ----
// Register map, field positions, reset values and event carrier for the flash status block.
// Assumes an 8-bit register port and a command sequencer that reports events as one-cycle pulses.
package flash_status_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses.
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CONFIG   = 16'h3024;
  localparam logic [15:0] ADDR_ERR_CFG  = 16'h3025;
  localparam logic [15:0] ADDR_STATUS   = 16'h3026;
  localparam logic [15:0] ADDR_ERR_STAT = 16'h3027;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int BIT_CMD_DONE_IRQ_EN = 7;
  localparam int BIT_IGNORE_SF       = 4;
  localparam int BIT_FORCE_DF        = 1;
  localparam int BIT_FORCE_SF        = 0;
  localparam int BIT_DF_IRQ_EN       = 1;
  localparam int BIT_SF_IRQ_EN       = 0;
  localparam int BIT_CMD_DONE        = 7;
  localparam int BIT_ACC_ERR         = 5;
  localparam int BIT_DF_FLAG         = 1;
  localparam int BIT_SF_FLAG         = 0;

  // ----------------------------------------------------------------
  // Reset values and implemented-bit masks.
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_STATUS    = 8'h80;
  localparam logic [7:0] RST_CONFIG    = 8'h00;
  localparam logic [7:0] RST_ERR_CFG   = 8'h00;
  localparam logic [7:0] RST_ERR_STAT  = 8'h00;
  localparam logic [7:0] MASK_CONFIG   = 8'h93;
  localparam logic [7:0] MASK_ERR_CFG  = 8'h03;
  localparam logic [7:0] MASK_STATUS   = 8'ha0;
  localparam logic [7:0] MASK_ERR_STAT = 8'h03;

  // ----------------------------------------------------------------
  // Events from the command sequencer and array read path.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cmd_done;
    logic cmd_violation;
    logic seq_error;
    logic array_read;
    logic single_fault;
    logic double_fault;
  } seq_evt_s;

endpackage

// ---- verif/tb_flash_status_error_irq_ctrl.sv ----
// Self-checking testbench for the flash status, configuration and interrupt block.
// Assumes the block's register port and one-cycle sequencer event pulses, one clock.
module tb_flash_status_error_irq_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_status_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals.
  // ----------------------------------------------------------------
  logic        i_core_clk;
  logic        i_sys_rst;
  logic [15:0] i_addr;
  logic [7:0]  i_wr_data;
  logic        i_wr_en;
  logic        i_rd_en;
  seq_evt_s    i_seq_evt;
  logic [7:0]  o_rd_data;
  logic        o_cmd_launch;
  logic        o_cmd_irq;
  logic        o_fault_irq;
  logic        o_irq;
  logic        launch_seen;
  int          fail_count;
  int          check_count;

  flash_status_error_irq_ctrl u_flash_status_error_irq_ctrl (
    .i_core_clk   (i_core_clk),
    .i_sys_rst    (i_sys_rst),
    .i_addr       (i_addr),
    .i_wr_data    (i_wr_data),
    .i_wr_en      (i_wr_en),
    .i_rd_en      (i_rd_en),
    .i_seq_evt    (i_seq_evt),
    .o_rd_data    (o_rd_data),
    .o_cmd_launch (o_cmd_launch),
    .o_cmd_irq    (o_cmd_irq),
    .o_fault_irq  (o_fault_irq),
    .o_irq        (o_irq)
  );

  always #50 i_core_clk = ~i_core_clk;

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr    <= a;
    i_wr_data <= d;
    i_wr_en   <= 1'b1;
    @(negedge i_core_clk);
    launch_seen = o_cmd_launch;
    @(posedge i_core_clk);
    i_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_rd_en <= 1'b1;
    @(posedge i_core_clk);
    i_rd_en <= 1'b0;
    @(negedge i_core_clk);
    chk(o_rd_data, exp, "read data");
    @(negedge i_core_clk);
    chk(o_rd_data, 8'h00, "idle read data");
  endtask

  task automatic evt(input logic [5:0] e);
    @(posedge i_core_clk);
    i_seq_evt <= seq_evt_s'(e);
    @(posedge i_core_clk);
    i_seq_evt <= seq_evt_s'(6'h00);
  endtask

  task automatic chk_irq(input logic [2:0] e);
    @(negedge i_core_clk);
    chk({5'h00, o_cmd_irq, o_fault_irq, o_irq}, {5'h00, e}, "irq outputs");
  endtask

  // ----------------------------------------------------------------
  // Watchdog.
  // ----------------------------------------------------------------
  initial begin
    repeat (3000) @(posedge i_core_clk);
    fail_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    i_core_clk  = 1'b0;
    i_sys_rst   = 1'b1;
    i_addr      = 16'h0000;
    i_wr_data   = 8'h00;
    i_wr_en     = 1'b0;
    i_rd_en     = 1'b0;
    i_seq_evt   = seq_evt_s'(6'h00);
    launch_seen = 1'b0;
    fail_count  = 0;
    check_count = 0;
    repeat (4) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rd(ADDR_CONFIG, 8'h00);
    rd(ADDR_ERR_CFG, 8'h00);
    rd(ADDR_STATUS, 8'h80);
    rd(ADDR_ERR_STAT, 8'h00);
    rd(16'h3020, 8'h00);
    chk_irq(3'h0);
    wr(ADDR_CONFIG, 8'hff);
    rd(ADDR_CONFIG, 8'h93);
    wr(ADDR_ERR_CFG, 8'hff);
    rd(ADDR_ERR_CFG, 8'h03);
    wr(ADDR_STATUS, 8'h5f);
    chk({7'h00, launch_seen}, 8'h00, "launch on clear write");
    rd(ADDR_STATUS, 8'h80);
    chk_irq(3'h5);
    wr(ADDR_CONFIG, 8'h80);
    wr(ADDR_ERR_CFG, 8'h00);
    wr(ADDR_STATUS, 8'h80);
    chk({7'h00, launch_seen}, 8'h01, "launch pulse");
    chk_irq(3'h0);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_STATUS, 8'h80);
    chk({7'h00, launch_seen}, 8'h00, "launch while running");
    evt(6'h20);
    chk_irq(3'h5);
    rd(ADDR_STATUS, 8'h80);
    wr(ADDR_CONFIG, 8'h00);
    chk_irq(3'h0);
    evt(6'h08);
    rd(ADDR_STATUS, 8'ha0);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'ha0);
    wr(ADDR_STATUS, 8'h80);
    chk({7'h00, launch_seen}, 8'h00, "launch with access error");
    rd(ADDR_STATUS, 8'ha0);
    wr(ADDR_STATUS, 8'h20);
    rd(ADDR_STATUS, 8'h80);
    wr(ADDR_STATUS, 8'h80);
    chk({7'h00, launch_seen}, 8'h01, "second launch");
    evt(6'h10);
    rd(ADDR_STATUS, 8'ha0);
    wr(ADDR_STATUS, 8'h20);
    wr(ADDR_ERR_CFG, 8'h03);
    evt(6'h06);
    rd(ADDR_ERR_STAT, 8'h01);
    chk_irq(3'h3);
    wr(ADDR_ERR_CFG, 8'h02);
    chk_irq(3'h0);
    wr(ADDR_ERR_STAT, 8'h01);
    rd(ADDR_ERR_STAT, 8'h00);
    wr(ADDR_CONFIG, 8'h10);
    evt(6'h06);
    rd(ADDR_ERR_STAT, 8'h00);
    wr(ADDR_ERR_CFG, 8'h03);
    chk_irq(3'h0);
    wr(ADDR_CONFIG, 8'h00);
    evt(6'h04);
    rd(ADDR_ERR_STAT, 8'h00);
    evt(6'h05);
    rd(ADDR_ERR_STAT, 8'h02);
    chk_irq(3'h3);
    wr(ADDR_ERR_STAT, 8'h02);
    wr(ADDR_CONFIG, 8'h02);
    evt(6'h04);
    rd(ADDR_ERR_STAT, 8'h02);
    rd(ADDR_CONFIG, 8'h02);
    chk_irq(3'h3);
    wr(ADDR_ERR_CFG, 8'h01);
    chk_irq(3'h0);
    wr(ADDR_ERR_STAT, 8'h02);
    wr(ADDR_CONFIG, 8'h00);
    rd(ADDR_CONFIG, 8'h00);
    wr(ADDR_CONFIG, 8'h11);
    evt(6'h04);
    rd(ADDR_ERR_STAT, 8'h01);
    rd(ADDR_CONFIG, 8'h11);
    chk_irq(3'h3);
    wr(ADDR_ERR_STAT, 8'h01);
    chk_irq(3'h0);
    wr(ADDR_CONFIG, 8'h10);
    rd(ADDR_CONFIG, 8'h10);
    test_done();
  end
endmodule
